// ==== rtl/fpfp_top.sv ====
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// [R1] FIFO port gives one byte per read; its address never moves.
// [R2] Host drains the FIFO port with repeated reads of that address.
// [R3] Frames are streamed; header presence follows the FIFO configuration.
// [R4] A partly read frame is resent whole, from its configured first byte, next readout.
// [R5] FIFO reads leave the new-data flag untouched.
// [R6] Three-bit page selector, read and write, resets to zero.
// [R7] Window at 0x30 shows configuration or results by selected page.
// [R8] Step count read-only: low word at 0x30, high word at 0x32.
// [R9] Gesture code at 0x36 is read-only, values zero to five.
// [R10] Activity code at 0x34 read-only, unknown after initialization.

module fpfp_top (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [fpfp_pkg::ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [fpfp_pkg::DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [fpfp_pkg::ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [fpfp_pkg::DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire fpfp_pkg::fpfp_byte_type FRAME_IN,
  input wire logic FRAME_IN_VALID,
  output logic FRAME_IN_READY,
  input wire logic NEW_DATA,
  input wire fpfp_pkg::fpfp_result_type RESULT_IN,
  input wire logic RESULT_VALID
);
  import fpfp_pkg::*;

  // ==========================================================
  // Decoding shared by the read and write paths
  function automatic logic in_window(input logic [5:0] idx);
    in_window = (idx[5:4] == IDX_WIN_BASE[5:4]) && !idx[0];
  endfunction

  // ==========================================================
  // Declarations
  logic aw_have_reg, w_have_reg, bvalid_reg, rvalid_reg;
  logic [5:0] aw_idx_reg;
  logic [31:0] wdata_reg, rdata_reg, rd_data_next;
  logic [3:0] wstrb_reg;
  logic [1:0] bresp_reg, rresp_reg, wr_resp_next, rd_resp_next;
  logic aw_hs, w_hs, ar_hs, wr_go;
  logic [5:0] rd_idx, aw_idx;
  logic [2:0] page_reg, page_next;
  logic [7:0] cfg_reg, cfg_next;
  logic new_data_reg, clear_new;
  logic store_we;
  logic [15:0] store_rdata;
  logic [31:0] step_reg;
  logic [1:0] act_reg;
  logic [2:0] gest_reg;
  logic readout_reg, end_readout, fifo_pop;
  logic [7:0] frame_byte;
  logic byte_valid;

  // ==========================================================
  // AXI4-Lite handshakes
  assign aw_idx = S_AXI_AWADDR[7:2];
  assign rd_idx = S_AXI_ARADDR[7:2];
  assign S_AXI_AWREADY = !aw_have_reg && !bvalid_reg;
  assign S_AXI_WREADY = !w_have_reg && !bvalid_reg;
  assign S_AXI_ARREADY = !rvalid_reg;
  assign aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_hs = S_AXI_WVALID && S_AXI_WREADY;
  assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
  assign wr_go = aw_have_reg && w_have_reg && !bvalid_reg;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RDATA = rdata_reg;
  assign S_AXI_RRESP = rresp_reg;

  // Address and data may arrive in either order
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      aw_have_reg <= 1'b0;
      aw_idx_reg <= 6'h00;
    end else if (aw_hs) begin
      aw_have_reg <= 1'b1;
      aw_idx_reg <= aw_idx;
    end else if (wr_go) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      w_have_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else if (w_hs) begin
      w_have_reg <= 1'b1;
      wdata_reg <= S_AXI_WDATA;
      wstrb_reg <= S_AXI_WSTRB;
    end else if (wr_go) begin
      w_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_go) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_resp_next;
    end else if (bvalid_reg && S_AXI_BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else if (ar_hs) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_data_next;
      rresp_reg <= rd_resp_next;
    end else if (rvalid_reg && S_AXI_RREADY) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Write decode
  always_comb begin
    page_next = page_reg;
    cfg_next = cfg_reg;
    clear_new = 1'b0;
    store_we = 1'b0;
    wr_resp_next = RESP_OKAY;
    if (aw_idx_reg == IDX_PAGE_SEL) begin
      if (wr_go && wstrb_reg[0]) begin
        page_next = wdata_reg[2:0]; // [R6]
      end
    end else if (aw_idx_reg == IDX_FIFO_CFG) begin
      if (wr_go && wstrb_reg[0]) begin
        cfg_next = wdata_reg[7:0];
      end
    end else if (aw_idx_reg == IDX_STATUS) begin
      clear_new = wr_go && wstrb_reg[0] && wdata_reg[STAT_NEW_BIT];
    end else if (in_window(aw_idx_reg)) begin
      // Result page is read-only; writes there are dropped quietly
      store_we = wr_go && (page_reg != RESULT_PAGE); // [R7]
    end else if (aw_idx_reg == IDX_FIFO_PORT) begin
      wr_resp_next = RESP_OKAY;
    end else begin
      wr_resp_next = RESP_SLVERR;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      page_reg <= PAGE_RESET; // [R6]
    end else begin
      page_reg <= page_next;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cfg_reg <= FIFO_CFG_RESET;
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Set wins over a clear in the same cycle; FIFO reads never clear
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      new_data_reg <= 1'b0;
    end else if (NEW_DATA) begin
      new_data_reg <= 1'b1;
    end else if (clear_new) begin
      new_data_reg <= 1'b0; // [R5]
    end
  end

  // ==========================================================
  // Feature results
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      step_reg <= 32'h00000000;
      act_reg <= ACT_UNKNOWN; // [R10]
      gest_reg <= GEST_UNKNOWN;
    end else if (RESULT_VALID) begin
      step_reg <= RESULT_IN.step; // [R8]
      act_reg <= RESULT_IN.act; // [R10]
      // Codes beyond the defined set read back as unknown
      gest_reg <= (RESULT_IN.gest > GEST_MAX) ? GEST_UNKNOWN : RESULT_IN.gest; // [R9]
    end
  end

  function automatic logic [15:0] result_word(input logic [5:0] idx);
    if (idx == IDX_STEP_LO) begin
      result_word = step_reg[15:0];
    end else if (idx == IDX_STEP_HI) begin
      result_word = step_reg[31:16];
    end else if (idx == IDX_ACT) begin
      result_word = {14'h0, act_reg};
    end else if (idx == IDX_GEST) begin
      result_word = {13'h0, gest_reg};
    end else begin
      result_word = 16'h0000;
    end
  endfunction

  fpfp_page_store u_store (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .we(store_we),
    .wr_page(page_reg),
    .wr_word(aw_idx_reg[3:1]),
    .wr_data(wdata_reg[15:0]),
    .wr_strb(wstrb_reg[1:0]),
    .rd_page(page_reg),
    .rd_word(rd_idx[3:1]),
    .rd_data(store_rdata)
  );

  // ==========================================================
  // Read decode
  always_comb begin
    rd_data_next = 32'h00000000;
    rd_resp_next = RESP_OKAY;
    if (rd_idx == IDX_FIFO_PORT) begin
      rd_data_next = {24'h000000, byte_valid ? frame_byte : FIFO_EMPTY_BYTE}; // [R1]
    end else if (rd_idx == IDX_PAGE_SEL) begin
      rd_data_next = {29'h0, page_reg}; // [R6]
    end else if (rd_idx == IDX_FIFO_CFG) begin
      rd_data_next = {24'h000000, cfg_reg};
    end else if (rd_idx == IDX_STATUS) begin
      rd_data_next[STAT_NEW_BIT] = new_data_reg;
      rd_data_next[STAT_AVAIL_BIT] = byte_valid;
    end else if (in_window(rd_idx)) begin
      if (page_reg == RESULT_PAGE) begin
        rd_data_next = {16'h0000, result_word(rd_idx)}; // [R7]
      end else begin
        rd_data_next = {16'h0000, store_rdata}; // [R7]
      end
    end else begin
      rd_resp_next = RESP_SLVERR;
    end
  end

  // ==========================================================
  // FIFO read-out; any other access ends the readout
  assign fifo_pop = ar_hs && (rd_idx == IDX_FIFO_PORT); // [R1]
  assign end_readout = readout_reg && ((ar_hs && rd_idx != IDX_FIFO_PORT)
                                      || (aw_hs && aw_idx != IDX_FIFO_PORT)); // [R4]

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      readout_reg <= 1'b0;
    end else if (fifo_pop) begin
      readout_reg <= 1'b1;
    end else if (end_readout) begin
      readout_reg <= 1'b0;
    end
  end

  fpfp_frame_replay u_replay (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .in_byte(FRAME_IN),
    .in_valid(FRAME_IN_VALID),
    .in_ready(FRAME_IN_READY),
    .pop(fifo_pop),
    .end_readout(end_readout),
    .hdr_en(cfg_reg[CFG_HDR_BIT]),
    .out_byte(frame_byte),
    .out_valid(byte_valid)
  );

  // ==========================================================
  // Checks
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence fifo_read_s;
    ar_hs && (rd_idx == IDX_FIFO_PORT) && byte_valid;
  endsequence

  sequence window_read_s(logic [2:0] pg);
    ar_hs && in_window(rd_idx) && (page_reg == pg);
  endsequence

  sequence fifo_empty_s;
    ar_hs && (rd_idx == IDX_FIFO_PORT) && !byte_valid;
  endsequence

  fifo_byte_a: assert property (fifo_read_s |=> S_AXI_RVALID && S_AXI_RDATA == {24'h000000, $past(frame_byte)}) // [R1]
    else $error("FIFO port returned wrong byte");

  new_data_keep_a: assert property (new_data_reg && fifo_pop && !clear_new |=> new_data_reg) // [R5]
    else $error("FIFO read cleared new-data flag");

  page_reset_a: assert property (disable iff (1'b0) !RST_N |=> page_reg == PAGE_RESET) // [R6]
    else $error("Page selector not zero after reset");

  page_write_a: assert property (wr_go && aw_idx_reg == IDX_PAGE_SEL && wstrb_reg[0] // [R6]
    |=> bvalid_reg && page_reg == $past(wdata_reg[2:0]))
    else $error("Page selector did not take written value");

  window_config_a: assert property (ar_hs && in_window(rd_idx) && page_reg != RESULT_PAGE // [R7]
    |=> S_AXI_RDATA == {16'h0000, $past(store_rdata)})
    else $error("Configuration page read mismatch");

  step_word_a: assert property (window_read_s(RESULT_PAGE) ##0 (rd_idx == IDX_STEP_HI) // [R8]
    |=> S_AXI_RDATA == {16'h0000, $past(step_reg[31:16])})
    else $error("Step count high word mismatch");

  gesture_range_a: assert property (S_AXI_RVALID && $rose(S_AXI_RVALID) // [R9]
    && $past(rd_idx == IDX_GEST && page_reg == RESULT_PAGE)
    |-> S_AXI_RDATA[2:0] <= GEST_MAX && S_AXI_RDATA[31:3] == 29'h0)
    else $error("Gesture code out of range");

  activity_init_a: assert property (disable iff (1'b0) !RST_N |=> act_reg == ACT_UNKNOWN) // [R10]
    else $error("Activity not unknown after reset");

  page_hold_a: assert property (!(wr_go && aw_idx_reg == IDX_PAGE_SEL) |=> page_reg == $past(page_reg)) // [R6]
    else $error("Page selector moved without a write");

  step_low_a: assert property (window_read_s(RESULT_PAGE) ##0 (rd_idx == IDX_STEP_LO) // [R8]
    |=> S_AXI_RDATA == {16'h0000, $past(step_reg[15:0])})
    else $error("Step count low word mismatch");

  activity_read_a: assert property (window_read_s(RESULT_PAGE) ##0 (rd_idx == IDX_ACT) // [R10]
    |=> S_AXI_RDATA == {30'h0, $past(act_reg)})
    else $error("Activity code mismatch");

  fifo_empty_a: assert property (fifo_empty_s |=> S_AXI_RDATA == {24'h000000, FIFO_EMPTY_BYTE}) // [R1]
    else $error("Empty FIFO port returned wrong byte");

  new_data_set_a: assert property (NEW_DATA |=> new_data_reg) // [R5]
    else $error("New-data flag not set");

endmodule

`default_nettype wire

// ==== rtl/fpfp_pkg.sv ====
package fpfp_pkg;

  // ==========================================================
  // Bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [5:0] IDX_FIFO_PORT = 6'h26;
  localparam logic [5:0] IDX_FIFO_CFG = 6'h28;
  localparam logic [5:0] IDX_STATUS = 6'h29;
  localparam logic [5:0] IDX_PAGE_SEL = 6'h2F;
  localparam logic [5:0] IDX_WIN_BASE = 6'h30;
  localparam logic [5:0] IDX_STEP_LO = 6'h30;
  localparam logic [5:0] IDX_STEP_HI = 6'h32;
  localparam logic [5:0] IDX_ACT = 6'h34;
  localparam logic [5:0] IDX_GEST = 6'h36;

  // ==========================================================
  // Fields and reset values
  localparam int CFG_HDR_BIT = 0;
  localparam int STAT_NEW_BIT = 0;
  localparam int STAT_AVAIL_BIT = 1;
  localparam logic [7:0] FIFO_CFG_RESET = 8'h01;
  localparam logic [7:0] FIFO_EMPTY_BYTE = 8'h80;
  localparam logic [2:0] PAGE_RESET = 3'h0;
  localparam logic [2:0] RESULT_PAGE = 3'h0;
  localparam int PAGES = 8;
  localparam int WIN_WORDS = 8;
  localparam logic [1:0] ACT_UNKNOWN = 2'h3;
  localparam logic [2:0] GEST_UNKNOWN = 3'h0;
  localparam logic [2:0] GEST_MAX = 3'h5;

  // ==========================================================
  // Frame buffer
  localparam int FRAME_BYTES = 16;
  localparam int FLEN_W = 5;
  localparam logic [4:0] FRAME_LEN_MAX = 5'h10;

  typedef struct packed {
    logic last;
    logic [7:0] data;
  } fpfp_byte_type;

  typedef struct packed {
    logic [31:0] step;
    logic [1:0] act;
    logic [2:0] gest;
  } fpfp_result_type;

endpackage

// ==== rtl/fpfp_page_store.sv ====
`timescale 1ns/1ps
`default_nettype none

module fpfp_page_store (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [2:0] wr_page,
  input wire logic [2:0] wr_word,
  input wire logic [15:0] wr_data,
  input wire logic [1:0] wr_strb,
  input wire logic [2:0] rd_page,
  input wire logic [2:0] rd_word,
  output logic [15:0] rd_data
);
  import fpfp_pkg::*;

  // ==========================================================
  // Configuration words of every page
  logic [15:0] page_mem [PAGES*WIN_WORDS];

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      for (int i = 0; i < PAGES*WIN_WORDS; i++) begin
        page_mem[i] <= 16'h0000;
      end
    end else if (we) begin
      for (int b = 0; b < 2; b++) begin
        if (wr_strb[b]) begin
          page_mem[{wr_page, wr_word}][8*b +: 8] <= wr_data[8*b +: 8];
        end
      end
    end
  end

  assign rd_data = page_mem[{rd_page, rd_word}];

endmodule

`default_nettype wire

// ==== rtl/fpfp_frame_replay.sv ====
`timescale 1ns/1ps
`default_nettype none

module fpfp_frame_replay (
  input wire logic clk,
  input wire logic rst_n,
  input wire fpfp_pkg::fpfp_byte_type in_byte,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic pop,
  input wire logic end_readout,
  input wire logic hdr_en,
  output logic [7:0] out_byte,
  output logic out_valid
);
  import fpfp_pkg::*;

  typedef enum logic [1:0] {RP_FILL = 2'b01, RP_SERVE = 2'b10} fpfp_rp_state_type;

  // ==========================================================
  // Frame held whole until fully read, so it can be replayed
  fpfp_rp_state_type state_reg;
  logic [7:0] frame_mem [FRAME_BYTES];
  logic [FLEN_W-1:0] wr_ptr_reg, rd_ptr_reg, len_reg, start_ptr;
  logic in_hs, load, partial;

  assign in_ready = (state_reg == RP_FILL);
  assign in_hs = in_valid && in_ready;
  assign load = in_hs && in_byte.last;
  assign start_ptr = hdr_en ? 5'h00 : 5'h01; // [R3]
  assign out_valid = (state_reg == RP_SERVE) && (rd_ptr_reg < len_reg);
  assign out_byte = frame_mem[rd_ptr_reg[3:0]];
  assign partial = out_valid && (rd_ptr_reg != start_ptr);

  // Bytes past the frame limit are dropped, not wrapped
  always_ff @(posedge clk) begin
    if (in_hs && (wr_ptr_reg < FRAME_LEN_MAX)) begin
      frame_mem[wr_ptr_reg[3:0]] <= in_byte.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= 5'h00;
      len_reg <= 5'h00;
    end else if (load) begin
      wr_ptr_reg <= 5'h00;
      len_reg <= (wr_ptr_reg == FRAME_LEN_MAX) ? FRAME_LEN_MAX : wr_ptr_reg + 5'h01;
    end else if (in_hs && (wr_ptr_reg < FRAME_LEN_MAX)) begin
      wr_ptr_reg <= wr_ptr_reg + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= RP_FILL;
    end else begin
      case (state_reg)
        RP_FILL: begin
          if (load) begin
            state_reg <= RP_SERVE;
          end
        end
        RP_SERVE: begin
          if (rd_ptr_reg >= len_reg) begin
            state_reg <= RP_FILL;
          end
        end
        default: state_reg <= RP_FILL;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_ptr_reg <= 5'h00;
    end else if (load) begin
      rd_ptr_reg <= start_ptr; // [R3]
    end else if (end_readout && partial) begin
      rd_ptr_reg <= start_ptr; // [R4]
    end else if (pop && out_valid) begin
      rd_ptr_reg <= rd_ptr_reg + 5'h01; // [R1]
    end
  end

  // ==========================================================
  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence frame_loaded_s;
    load && (state_reg == RP_FILL);
  endsequence

  header_skip_a: assert property (frame_loaded_s |=> rd_ptr_reg == (hdr_en ? 5'h00 : 5'h01)) // [R3]
    else $error("Frame start does not follow header setting");
  retransmit_a: assert property (end_readout && partial |=> rd_ptr_reg == $past(start_ptr)) // [R4]
    else $error("Partial frame not rewound");
  pop_advance_a: assert property (pop && out_valid && !end_readout |=> rd_ptr_reg == $past(rd_ptr_reg) + 5'h01) // [R1]
    else $error("Read did not advance by one byte");

endmodule

`default_nettype wire

// ==== tb/fpfp_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Host side register master
module fpfp_host_model (
  input wire logic clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  // Answer ready lines stay high, so no release races between calls
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b1;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b1;
  end

  // ==========================================================
  // Write: address and data offered together
  task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge clk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
  endtask

  // ==========================================================
  // Read: repeated reads of one address drain the stream port
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask
endmodule

`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import fpfp_pkg::*;
  logic sys_clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, frame_valid, frame_ready, new_data, result_valid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  fpfp_byte_type frame_in;
  fpfp_result_type result_in;
  int fails, checks_done;
  int cfg_m [8][8];
  logic [31:0] s;
  logic [2:0] w;

  fpfp_top uut (.SYS_CLK(sys_clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .FRAME_IN(frame_in),
    .FRAME_IN_VALID(frame_valid), .FRAME_IN_READY(frame_ready), .NEW_DATA(new_data),
    .RESULT_IN(result_in), .RESULT_VALID(result_valid));

  fpfp_host_model host (.clk(sys_clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // ==========================================================
  // Clock and watchdog
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Whole run needs a few hundred cycles; generous margin
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    complete_run();
  end

  // ==========================================================
  // Shared checks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] er, input string what);
    logic [31:0] d;
    logic [1:0] r;
    host.read({idx, 2'b00}, d, r);
    chk(d, exp, what);
    chk({30'h0, r}, {30'h0, er}, what);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    host.write({idx, 2'b00}, d, r);
    chk({30'h0, r}, {30'h0, er}, "write response");
  endtask

  // ==========================================================
  // Frame load, partial readout, replay and drain
  task automatic frame_run(input int len, input bit hdr);
    logic [7:0] q[$];
    int first;
    first = hdr ? 0 : 1;
    wr(IDX_FIFO_CFG, {31'h0, hdr}, RESP_OKAY);
    for (int i = 0; i < len; i++) q.push_back(8'($urandom));
    for (int i = 0; i < len; i++) begin
      frame_in <= '{last: (i == len - 1), data: q[i]};
      frame_valid <= 1'b1;
      do @(posedge sys_clk); while (frame_ready !== 1'b1);
    end
    frame_valid <= 1'b0;
    new_data <= 1'b1;
    @(posedge sys_clk);
    new_data <= 1'b0;
    chk({31'h0, frame_ready}, 32'h0, "ready while held");
    rd(IDX_FIFO_PORT, {24'h0, q[first]}, RESP_OKAY, "first byte");
    rd(IDX_FIFO_PORT, {24'h0, q[first + 1]}, RESP_OKAY, "second byte");
    rd(IDX_STATUS, 32'h3, RESP_OKAY, "status mid frame");
    for (int i = first; i < len; i++) rd(IDX_FIFO_PORT, {24'h0, q[i]}, RESP_OKAY, "replayed byte");
    rd(IDX_FIFO_PORT, {24'h0, FIFO_EMPTY_BYTE}, RESP_OKAY, "empty port");
    chk({31'h0, frame_ready}, 32'h1, "ready after drain");
    rd(IDX_STATUS, 32'h1, RESP_OKAY, "status drained");
    wr(IDX_STATUS, 32'h1, RESP_OKAY);
    rd(IDX_STATUS, 32'h0, RESP_OKAY, "status cleared");
    $display("test frame len %0d header %0d done", len, hdr);
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst_n = 1'b0;
    frame_in = '0;
    frame_valid = 1'b0;
    new_data = 1'b0;
    result_in = '0;
    result_valid = 1'b0;
    fails = 0;
    checks_done = 0;
    void'($urandom(32'h928c));
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rd(IDX_PAGE_SEL, 32'h0, RESP_OKAY, "page reset");
    rd(IDX_STEP_LO, 32'h0, RESP_OKAY, "step low reset");
    rd(IDX_STEP_HI, 32'h0, RESP_OKAY, "step high reset");
    rd(IDX_ACT, {30'h0, ACT_UNKNOWN}, RESP_OKAY, "activity reset");
    rd(IDX_GEST, {29'h0, GEST_UNKNOWN}, RESP_OKAY, "gesture reset");
    rd(IDX_FIFO_CFG, {24'h0, FIFO_CFG_RESET}, RESP_OKAY, "fifo config reset");
    rd(6'h01, 32'h0, RESP_SLVERR, "unmapped read");
    rd(6'h31, 32'h0, RESP_SLVERR, "odd window read");
    $display("test reset values done");
    // Upper garbage in page writes shows the selector is three bits wide
    for (int p = 1; p < PAGES; p++) begin
      s = $urandom;
      w = 3'($urandom_range(7));
      wr(IDX_PAGE_SEL, {s[31:3], 3'(p)}, RESP_OKAY);
      wr(6'(IDX_WIN_BASE + 2 * w), s, RESP_OKAY);
      cfg_m[p][w] = s[15:0];
    end
    for (int p = PAGES - 1; p > 0; p--) begin
      wr(IDX_PAGE_SEL, 32'(p), RESP_OKAY);
      rd(IDX_PAGE_SEL, 32'(p), RESP_OKAY, "page readback");
      for (int k = 0; k < WIN_WORDS; k++) begin
        rd(6'(IDX_WIN_BASE + 2 * k), 32'(cfg_m[p][k]), RESP_OKAY, "config word");
      end
    end
    wr(IDX_PAGE_SEL, {29'h0, RESULT_PAGE}, RESP_OKAY);
    wr(IDX_STEP_LO, $urandom, RESP_OKAY);
    rd(IDX_STEP_LO, 32'h0, RESP_OKAY, "step low read only");
    $display("test feature pages done");
    // Every gesture code, plus two out of range
    for (int g = 0; g < 8; g++) begin
      s = $urandom;
      result_in <= '{step: s, act: 2'(g), gest: 3'(g)};
      result_valid <= 1'b1;
      @(posedge sys_clk);
      result_valid <= 1'b0;
      wr(IDX_GEST, 32'h7, RESP_OKAY);
      rd(IDX_STEP_LO, {16'h0, s[15:0]}, RESP_OKAY, "step low");
      rd(IDX_STEP_HI, {16'h0, s[31:16]}, RESP_OKAY, "step high");
      rd(IDX_ACT, 32'(g % 4), RESP_OKAY, "activity");
      rd(IDX_GEST, (g > 5) ? 32'h0 : 32'(g), RESP_OKAY, "gesture");
    end
    $display("test results done");
    frame_run(3, 1'b1);
    frame_run(FRAME_BYTES, 1'b0);
    frame_run(FRAME_BYTES, 1'b1);
    complete_run();
  end
endmodule

`default_nettype wire
